// file: core/pmg_consts.svh
/*
 * Constants of the priority mask and grouping block: sizes, register offsets,
 * field positions, reset values. Assumes inclusion by bare name.
 */
`ifndef PMG_CONSTS_SVH
`define PMG_CONSTS_SVH
`define PMG_NUM_SRC      8
`define PMG_IDX_W        3
`define PMG_PRIO_W       8
`define PMG_IMPL_MASK    8'hF8
`define PMG_BPR_MIN      3'h2
`define PMG_GROUPING     1'b1
`define PMG_THRESH_RST   8'h00
`define PMG_BPR_RST      3'h2
`define PMG_IDLE_RUN     9'h100
`define PMG_ADDR_W       8
`define PMG_OFS_THRESH   8'h00
`define PMG_OFS_BPR      8'h04
`define PMG_OFS_ABPR     8'h08
`define PMG_OFS_CTRL     8'h0C
`define PMG_OFS_RUN      8'h10
`define PMG_OFS_PEND     8'h14
`define PMG_CTRL_COMMON_BINARY_POINT_SEL    0
`define PMG_PEND_ID_LSB  8
`define PMG_PEND_VALID   16
`define PMG_PEND_IRQ     17
`endif

// file: core/pmg_pkg.sv
/*
 * Types of the priority mask and grouping block.
 * Assumes pmg_consts.svh is on the include path.
 */
`include "pmg_consts.svh"
package pmg_pkg;
    typedef logic [`PMG_PRIO_W-1:0] pmg_prio_t;
    typedef pmg_prio_t [`PMG_NUM_SRC-1:0] pmg_prio_vec_t;
    typedef struct packed {
        logic [`PMG_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
        logic                   wr;
        logic                   rd;
        logic                   nonsecure;
    } pmg_bus_req_t;
    typedef struct packed {
        pmg_prio_t              thresh;
        logic [2:0]             bpr_s;
        logic [2:0]             bpr_ns;
        logic                   common_binary_point_sel;
        logic                   irq;
        logic [`PMG_IDX_W-1:0]  irq_id;
        pmg_prio_t              irq_prio;
        logic [8:0]             run_prio;
        logic [31:0]            rdata;
    } pmg_state_t;
endpackage

// file: core/pmg_prio_filter.sv
/*
 * Priority filter of one processor interface: threshold masking, group and
 * subpriority split by binary point, preemption check against the running
 * priority, and winner selection among pending sources.
 * Assumes pending, active, priority and group inputs come from logic on the
 * same clock, and a register master that never issues read and write at once.
 */
// Notes on behaviour
// - signal only when priority value is numerically below the threshold.
// - threshold resets to zero, and zero blocks every interrupt.
// - threshold compare uses the full implemented priority, no grouping.
// - an interrupt at the largest supported priority value is never signaled.
// - writing 255 to the threshold stores the largest supported priority.
// - with something active, only a strictly lower group value may be signaled.
// - equal group priorities count as equal for preemption, whatever subpriority.
// - with nothing active, the best pending interrupt passes, threshold permitting.
// - binary point N puts group in bits 7 to N+1; N of 7 means none.
// - the binary point in use never falls below a fixed minimum.
// - group 0 uses primary point; group 1 uses alias unless common select.
// - without grouping, one binary point register serves every interrupt.
// - alias point and non-secure primary copy share one storage.
// - among equal group values the lowest subpriority wins.
// - full ties go to the lowest source index.
// - priorities are 8-bit unsigned, zero most urgent.
// - five upper priority bits implemented; lower bits read zero, ignore writes.
`timescale 1ns/10ps
`include "pmg_consts.svh"
module pmg_prio_filter (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_b,
    input  wire pmg_pkg::pmg_bus_req_t   i_bus,
    input  wire logic [`PMG_NUM_SRC-1:0] i_pending,
    input  wire logic [`PMG_NUM_SRC-1:0] i_active,
    input  wire logic [`PMG_NUM_SRC-1:0] i_group1,
    input  wire pmg_pkg::pmg_prio_vec_t  i_prio,
    output logic [31:0]                  o_rdata,
    output logic                         o_irq,
    output logic [`PMG_IDX_W-1:0]        o_irq_id,
    output logic [`PMG_PRIO_W-1:0]       o_irq_prio,
    output logic [8:0]                   o_run_prio
);

    pmg_pkg::pmg_state_t state;
    pmg_pkg::pmg_state_t next_state;

    // low-order bits that are not implemented are forced to zero
    function automatic pmg_pkg::pmg_prio_t impl_prio(input pmg_pkg::pmg_prio_t p);
        return p & `PMG_IMPL_MASK;
    endfunction

    function automatic logic [2:0] bp_clamp(input logic [2:0] b);
        return (b < `PMG_BPR_MIN) ? `PMG_BPR_MIN : b;
    endfunction

    // group field kept in place; binary point 7 yields zero for all, so no
    // group can ever be strictly below another
    function automatic pmg_pkg::pmg_prio_t group_of(input pmg_pkg::pmg_prio_t p,
                                                    input logic [2:0]         n);
        logic [8:0] m;
        m = 9'h1FE << n;
        return p & m[7:0];
    endfunction

    function automatic logic [2:0] bp_select(input logic       grp1,
                                             input logic [2:0] bs,
                                             input logic [2:0] bns,
                                             input logic       cb);
        logic [2:0] b;
        if (!`PMG_GROUPING) begin
            b = bs;
        end else if (grp1 && !cb) begin
            b = bns;
        end else begin
            b = bs;
        end
        return bp_clamp(b);
    endfunction

    function automatic logic [31:0] read_mux(input logic [`PMG_ADDR_W-1:0] a,
                                            input pmg_pkg::pmg_state_t    s,
                                            input logic                   ns,
                                            input logic [31:0]            pend_word);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `PMG_OFS_THRESH: begin
                d[7:0] = s.thresh;
            end
            `PMG_OFS_BPR: begin
                d[2:0] = (ns && `PMG_GROUPING) ? s.bpr_ns : s.bpr_s;
            end
            `PMG_OFS_ABPR: begin
                d[2:0] = `PMG_GROUPING ? s.bpr_ns : 3'h0;
            end
            `PMG_OFS_CTRL: begin
                d[`PMG_CTRL_COMMON_BINARY_POINT_SEL] = s.common_binary_point_sel;
            end
            `PMG_OFS_RUN: begin
                d[8:0] = s.run_prio;
            end
            `PMG_OFS_PEND: begin
                d = pend_word;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    always_comb begin
        logic                  any_active;
        logic [8:0]            run_grp;
        pmg_pkg::pmg_prio_t    best_act;
        logic [2:0]            act_bp;
        logic                  cand_valid;
        logic [`PMG_IDX_W-1:0] cand_id;
        pmg_pkg::pmg_prio_t    cand_prio;
        logic [2:0]            cand_bp;
        pmg_pkg::pmg_prio_t    p;
        logic                  below_mask;
        logic                  not_lowest;
        logic                  preempt_ok;
        logic                  fire;
        logic [31:0]           pend_word;
        logic [7:0]            wbyte;

        any_active = 1'b0;
        run_grp    = `PMG_IDLE_RUN;
        best_act   = 8'hFF;
        act_bp     = `PMG_BPR_MIN;
        cand_valid = 1'b0;
        cand_id    = '0;
        cand_prio  = 8'hFF;
        cand_bp    = `PMG_BPR_MIN;
        p          = 8'h00;
        below_mask = 1'b0;
        not_lowest = 1'b0;
        preempt_ok = 1'b0;
        fire       = 1'b0;
        pend_word  = 32'h0000_0000;
        wbyte      = i_bus.wdata[7:0];
        next_state = state;

        // most urgent active source sets the running priority
        for (int i = 0; i < `PMG_NUM_SRC; i++) begin
            p = impl_prio(i_prio[i]);
            if (i_active[i] && (!any_active || p < best_act)) begin
                any_active = 1'b1;
                best_act   = p;
                act_bp     = bp_select(i_group1[i], state.bpr_s, state.bpr_ns, state.common_binary_point_sel);
            end
        end
        if (any_active) begin
            run_grp = {1'b0, group_of(best_act, act_bp)};
        end

        // strict less-than keeps the lowest index on full ties; comparing the
        // whole value orders by group first, then by subpriority
        for (int i = 0; i < `PMG_NUM_SRC; i++) begin
            p = impl_prio(i_prio[i]);
            if (i_pending[i] && !i_active[i] && (!cand_valid || p < cand_prio)) begin
                cand_valid = 1'b1;
                cand_id    = i[`PMG_IDX_W-1:0];
                cand_prio  = p;
                cand_bp    = bp_select(i_group1[i], state.bpr_s, state.bpr_ns, state.common_binary_point_sel);
            end
        end

        below_mask = cand_prio < state.thresh;
        not_lowest = cand_prio != `PMG_IMPL_MASK;
        if (!any_active) begin
            preempt_ok = 1'b1;
        end else begin
            preempt_ok = {1'b0, group_of(cand_prio, cand_bp)} < run_grp;
        end
        fire = cand_valid && below_mask && not_lowest && preempt_ok;

        // outputs follow the inputs one cycle later, every cycle
        next_state.irq      = fire;
        next_state.irq_id   = fire ? cand_id : '0;
        next_state.irq_prio = fire ? cand_prio : 8'h00;
        next_state.run_prio = run_grp;

        pend_word[7:0]                                  = cand_prio;
        pend_word[`PMG_PEND_ID_LSB +: `PMG_IDX_W]       = cand_id;
        pend_word[`PMG_PEND_VALID]                      = cand_valid;
        pend_word[`PMG_PEND_IRQ]                        = state.irq;

        if (i_bus.wr) begin
            case (i_bus.addr)
                `PMG_OFS_THRESH: begin
                    // 0xFF masks down to the largest implemented value
                    next_state.thresh = impl_prio(wbyte);
                end
                `PMG_OFS_BPR: begin
                    if (i_bus.nonsecure && `PMG_GROUPING) begin
                        next_state.bpr_ns = bp_clamp(wbyte[2:0]);
                    end else begin
                        next_state.bpr_s = bp_clamp(wbyte[2:0]);
                    end
                end
                `PMG_OFS_ABPR: begin
                    if (`PMG_GROUPING) begin
                        next_state.bpr_ns = bp_clamp(wbyte[2:0]);
                    end
                end
                `PMG_OFS_CTRL: begin
                    next_state.common_binary_point_sel = wbyte[`PMG_CTRL_COMMON_BINARY_POINT_SEL];
                end
                default: begin
                end
            endcase
        end

        // read data stand only in the cycle after the strobe
        if (i_bus.rd) begin
            next_state.rdata = read_mux(i_bus.addr, state, i_bus.nonsecure, pend_word);
        end else begin
            next_state.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state.thresh   <= `PMG_THRESH_RST;
            state.bpr_s    <= `PMG_BPR_RST;
            state.bpr_ns   <= `PMG_BPR_RST;
            state.common_binary_point_sel     <= 1'b0;
            state.irq      <= 1'b0;
            state.irq_id   <= '0;
            state.irq_prio <= 8'h00;
            state.run_prio <= `PMG_IDLE_RUN;
            state.rdata    <= 32'h0000_0000;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata    = state.rdata;
    assign o_irq      = state.irq;
    assign o_irq_id   = state.irq_id;
    assign o_irq_prio = state.irq_prio;
    assign o_run_prio = state.run_prio;

endmodule

// file: verif/pmg_prio_props.sv
/* port checker of the priority filter.
   assumes one clock, async active-low reset, bound to every filter instance. */
`timescale 1ns/10ps
`include "pmg_consts.svh"
module pmg_prio_props (
    input wire logic                    i_clk_sys,
    input wire logic                    i_rst_b,
    input wire pmg_pkg::pmg_bus_req_t   i_bus,
    input wire logic [`PMG_NUM_SRC-1:0] i_pending,
    input wire logic [`PMG_NUM_SRC-1:0] i_active,
    input wire logic [`PMG_NUM_SRC-1:0] i_group1,
    input wire pmg_pkg::pmg_prio_vec_t  i_prio,
    input wire logic [31:0]             o_rdata,
    input wire logic                    o_irq,
    input wire logic [`PMG_IDX_W-1:0]   o_irq_id,
    input wire logic [`PMG_PRIO_W-1:0]  o_irq_prio,
    input wire logic [8:0]              o_run_prio
);
    logic [7:0]             pend_q, act_q;
    pmg_pkg::pmg_prio_vec_t prio_q;
    logic                   rd_q, bad_q, thr_set;
    // inputs one edge back line up with the registered outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {pend_q, act_q, prio_q, rd_q, bad_q, thr_set} <= '0;
        end else begin
            {pend_q, act_q, prio_q, rd_q} <= {i_pending, i_active, i_prio, i_bus.rd};
            bad_q <= i_bus.rd && (i_bus.addr > 8'h14 || i_bus.addr[1:0] != 2'h0);
            thr_set <= thr_set | (i_bus.wr && i_bus.addr == 8'h00);
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    property p_rd_once; !rd_q |-> o_rdata == 32'h0; endproperty
    property p_unmap; bad_q |-> o_rdata == 32'h0; endproperty
    property p_quiet; !o_irq |-> o_irq_id == 3'h0 && o_irq_prio == 8'h00; endproperty
    property p_no_max; o_irq |-> o_irq_prio != 8'hF8 && o_irq_prio[2:0] == 3'h0; endproperty
    property p_cand; o_irq |-> pend_q[o_irq_id] && !act_q[o_irq_id]; endproperty
    property p_prio; o_irq |-> o_irq_prio == (prio_q[o_irq_id] & 8'hF8); endproperty
    property p_idle; act_q == 8'h00 |-> o_run_prio == 9'h100; endproperty
    property p_busy; act_q != 8'h00 |-> !o_run_prio[8]; endproperty
    property p_thr; !thr_set |-> !o_irq; endproperty
    property p_nopre; o_irq && act_q != 8'h00 |-> o_run_prio[7:0] != 8'h00; endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data outside its slot");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_quiet: assert property (p_quiet) else $error("idle request fields not zero");
    a_no_max: assert property (p_no_max) else $error("bad priority signaled");
    a_cand: assert property (p_cand) else $error("winner not a pending idle source");
    a_prio: assert property (p_prio) else $error("winner priority wrong");
    a_idle: assert property (p_idle) else $error("running priority not idle");
    a_busy: assert property (p_busy) else $error("running priority idle while active");
    a_thr: assert property (p_thr) else $error("request before threshold written");
    a_nopre: assert property (p_nopre) else $error("preemption past group zero");
    c_pre: cover property (o_irq && act_q != 8'h00);
    c_irq: cover property ($rose(o_irq));
    c_rd: cover property (rd_q && o_rdata != 32'h0);
endmodule
bind pmg_prio_filter pmg_prio_props chk_u (.i_clk_sys, .i_rst_b, .i_bus, .i_pending, .i_active, .i_group1,
    .i_prio, .o_rdata, .o_irq, .o_irq_id, .o_irq_prio, .o_run_prio);

// file: verif/pmg_core_model.sv
/* far-side core: takes a signaled source into active on ack, drops one on end.
   assumes the filter's clock and reset. */
`timescale 1ns/10ps
module pmg_core_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_irq,
    input  wire logic [2:0] i_irq_id,
    input  wire logic       i_ack,
    input  wire logic       i_eoi,
    input  wire logic [2:0] i_eoi_id,
    output logic      [7:0] o_active
);
    // only what is signaled at that very edge can be taken, as on a real core
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) o_active <= '0;
        else begin
            if (i_ack && i_irq) o_active[i_irq_id] <= 1'b1;
            if (i_eoi) o_active[i_eoi_id] <= 1'b0;
        end
    end
endmodule

// file: verif/tb.sv
/* bench of the priority filter: model compare of registers and request.
   assumes the filter, its package and the core model are compiled first. */
`timescale 1ns/10ps
module tb;
    logic                   i_clk_sys = 0, i_rst_b = 0, ack = 0, eoi = 0, irq;
    pmg_pkg::pmg_bus_req_t  bus = '0;
    logic [7:0]             pend = 0, g1 = 0, act, iprio;
    logic [2:0]             eid = 0, id;
    pmg_pkg::pmg_prio_vec_t prio = '0;
    logic [31:0]            rdata;
    logic [8:0]             run;
    int                     fail_count = 0, checks = 0, cyc = 0, thr = 0, bs = 2, bns = 2, cb = 0, v;
    int                     ew = 0, er = 'h100;
    always #2.5 i_clk_sys = ~i_clk_sys;
    pmg_prio_filter dut_u (.i_clk_sys, .i_rst_b, .i_bus(bus), .i_pending(pend), .i_active(act),
        .i_group1(g1), .i_prio(prio), .o_rdata(rdata), .o_irq(irq), .o_irq_id(id), .o_irq_prio(iprio),
        .o_run_prio(run));
    pmg_core_model core_u (.i_clk_sys, .i_rst_b, .i_irq(irq), .i_irq_id(id), .i_ack(ack), .i_eoi(eoi),
        .i_eoi_id(eid), .o_active(act));
    task automatic wrap_up();
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge i_clk_sys) if (++cyc == 6000) begin
        fail_count++;
        wrap_up();
    end
    task automatic acc(input logic w, input logic [7:0] a, input int d, input logic ns = 0);
        @(posedge i_clk_sys);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w, nonsecure: ns};
        @(posedge i_clk_sys);
        bus <= '0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic ns = 0);
        acc(0, a, 0, ns);
        #1 checks++;
        if (rdata !== e) begin
            fail_count++;
            $display("[FAIL] %0t read %h got %h", $time, a, rdata);
        end
    endtask
    // group value of priority p under the binary point that source i uses
    function automatic int grp(int p, int i);
        int n = (!g1[i] || cb) ? bs : bns;
        return n == 7 ? 0 : p & 'hF8 & ('hFF << (n + 1));
    endfunction
    task automatic chk_irq();
        int b = -1, r = -1, rp = 'h100, ep = 0;
        for (int i = 0; i < 8; i++) begin
            if (act[i] && (r < 0 || (prio[i] & 'hF8) < (prio[r] & 'hF8))) r = i;
            if (pend[i] && !act[i] && (b < 0 || (prio[i] & 'hF8) < (prio[b] & 'hF8))) b = i;
        end
        if (r >= 0) rp = grp(prio[r], r);
        if (b >= 0) ep = prio[b] & 'hF8;
        // best pending word is taken before masking; no candidate reads as 0xFF
        ew = b < 0 ? 'hFF : (1 << 16) | (b << 8) | ep;
        er = rp;
        if (b >= 0 && (ep >= thr || ep == 'hF8 || (r >= 0 && grp(ep, b) >= rp))) b = -1;
        if (b >= 0) ew = ew | (1 << 17);
        if (b < 0) ep = 0;
        checks++;
        if (irq !== 1'(b >= 0) || id !== 3'(b < 0 ? 0 : b) || iprio !== 8'(ep) || run !== 9'(rp)) begin
            fail_count++;
            $display("[FAIL] %0t request %b %0d %h %h", $time, irq, id, iprio, run);
        end
    endtask
    initial begin
        void'($urandom(32'h3724));
        repeat (12) @(posedge i_clk_sys);
        i_rst_b <= 1;
        chk_reg(8'h00, 0);
        chk_reg(8'h04, 2);
        @(posedge i_clk_sys);
        pend <= 8'hFF;
        prio <= {8{8'h10}};
        repeat (3) @(posedge i_clk_sys);
        #1 chk_irq();
        acc(1, 8'h00, 'hFF);
        thr = 'hF8;
        chk_reg(8'h00, 32'hF8);
        acc(1, 8'h04, 0);
        chk_reg(8'h04, 2);
        acc(1, 8'h08, 5);
        chk_reg(8'h04, 5, 1);
        chk_reg(8'h21, 0);
        // second half: one pending source, so the two binary points differ safely
        for (int k = 0; k < 80; k++) begin
            v = $urandom;
            acc(1, 8'h00, v & 'hFF);
            thr = v & 'hF8;
            v = $urandom % 8;
            acc(1, 8'h04, v);
            bs = v < 2 ? 2 : v;
            if (k >= 40) v = $urandom % 8;
            acc(1, 8'h08, v);
            bns = v < 2 ? 2 : v;
            cb = $urandom % 2;
            acc(1, 8'h0C, cb);
            @(posedge i_clk_sys);
            pend <= k < 40 ? 8'($urandom) : 8'(1 << ($urandom % 8));
            g1 <= 8'($urandom);
            prio <= {$urandom, $urandom};
            ack <= 1'($urandom);
            eoi <= $urandom % 3 == 0;
            eid <= 3'($urandom);
            @(posedge i_clk_sys);
            ack <= 0;
            eoi <= 0;
            repeat (2) @(posedge i_clk_sys);
            #1 chk_irq();
            chk_reg(8'h10, er);
            chk_reg(8'h14, ew);
            chk_reg(8'h0C, cb);
        end
        wrap_up();
    end
endmodule
